// ==== rtl/vcc_cfg.svh ====
// Register offsets, field positions and reset values of the capture channel
`ifndef VCC_CFG_SVH
`define VCC_CFG_SVH
`define VCC_ADDR_W 4
`define VCC_OFF_CH0 4'h0
`define VCC_OFF_CH1 4'h4
`define VCC_OFF_IRQ_STAT 4'h8
`define VCC_OFF_IRQ_MASK 4'hC
`define VCC_IRQ_SEL_HI 7
`define VCC_IRQ_SEL_LO 6
`define VCC_FID_BIT 5
`define VCC_LAYOUT_BIT 4
`define VCC_MUX_BIT 3
`define VCC_FMT_HI 2
`define VCC_FMT_LO 1
`define VCC_EN_BIT 0
`define VCC_CTRL_RST 8'h00
`define VCC_CTRL_WMASK 8'hDF
`define VCC_SEL_TOP 2'h0
`define VCC_SEL_BOT 2'h1
`define VCC_SEL_BOTH 2'h2
`define VCC_RESP_OKAY 2'h0
`define VCC_RESP_SLVERR 2'h2
`define VCC_IRQ_FRAME 0
`define VCC_IRQ_START 1
`define VCC_IRQ_W 2
`endif

// ==== rtl/vcc_channel_ctrl.sv ====
// Video capture channel 0 control register and frame logic
`timescale 1ns/1ps
`include "vcc_cfg.svh"
module vcc_channel_ctrl
    import vcc_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite slave
    input wire logic [`VCC_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [`VCC_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Video source pins
    input wire logic vid_clk,
    input wire logic vid_vsync,
    input wire logic vid_field,
    input wire logic [7:0] vid_data,
    input wire logic vid_blank,
    // Captured byte towards memory writer, capture status and interrupt
    output logic mem_wr_valid,
    output logic [7:0] mem_wr_data,
    output logic mem_wr_subpicture,
    output logic mem_wr_separate_lanes,
    output logic capture_active,
    output logic irq
);
    vcc_ctrl_s ctrl;
    vcc_ctrl_s act;
    vcc_video_s vid_s;
    vcc_state_e state;
    logic [1:0] ch1_irq_select;
    logic ch1_layout;
    logic channel1_luma_chroma_mux;
    logic [1:0] channel1_capture_format;
    logic channel1_enable;
    logic field_identity_flag;
    logic [`VCC_IRQ_W-1:0] irq_status;
    logic [`VCC_IRQ_W-1:0] irq_mask;
    logic aw_held;
    logic w_held;
    logic [`VCC_ADDR_W-1:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic clk_sync;
    logic clk_rise;
    logic vs_rise;
    logic vs_fall;
    logic blank_s;

    function automatic logic is_raw(input logic [1:0] fmt);
        return fmt[1];
    endfunction : is_raw

    // Places the control fields and the field flag in a register byte
    function automatic logic [7:0] pack_ctrl(input vcc_ctrl_s c,
                                             input logic fid);
        logic [7:0] b;
        b = 8'h00;
        b[`VCC_IRQ_SEL_HI:`VCC_IRQ_SEL_LO] = c.irq_select;
        b[`VCC_FID_BIT] = fid;
        b[`VCC_LAYOUT_BIT] = c.layout;
        b[`VCC_MUX_BIT] = c.mux;
        b[`VCC_FMT_HI:`VCC_FMT_LO] = c.format;
        b[`VCC_EN_BIT] = c.enable;
        return b;
    endfunction : pack_ctrl

    // Splits a register byte into the control fields
    function automatic vcc_ctrl_s unpack_ctrl(input logic [7:0] b);
        vcc_ctrl_s c;
        c.irq_select = b[`VCC_IRQ_SEL_HI:`VCC_IRQ_SEL_LO];
        c.layout = b[`VCC_LAYOUT_BIT];
        c.mux = b[`VCC_MUX_BIT];
        c.format = b[`VCC_FMT_HI:`VCC_FMT_LO];
        c.enable = b[`VCC_EN_BIT];
        return c;
    endfunction : unpack_ctrl

    // Pin synchronisers and link clock edge finder
    vcc_sync #(.WIDTH(12)) u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .async_in({vid_clk, vid_vsync, vid_field, vid_data, vid_blank}),
        .sync_out({clk_sync, vid_s, blank_s})
    );

    vcc_edge u_clk_edge (
        .aclk(aclk),
        .aresetn(aresetn),
        .level(clk_sync),
        .rise(clk_rise),
        .fall()
    );

    vcc_edge u_vs_edge (
        .aclk(aclk),
        .aresetn(aresetn),
        .level(vid_s.vsync),
        .rise(vs_rise),
        .fall(vs_fall)
    );

    // Write channel capture
    wire do_write = aw_held & w_held & ~s_axi_bvalid;
    wire sel_ch0 = aw_addr == `VCC_OFF_CH0;
    wire sel_ch1 = aw_addr == `VCC_OFF_CH1;
    wire sel_stat = aw_addr == `VCC_OFF_IRQ_STAT;
    wire sel_mask = aw_addr == `VCC_OFF_IRQ_MASK;
    wire wr_hit = sel_ch0 | sel_ch1 | sel_stat | sel_mask;
    wire wr_lane0 = do_write & w_strb[0];
    wire [7:0] wbyte = w_data[7:0];
    wire vcc_ctrl_s wr_ctrl = unpack_ctrl(wbyte);
    wire ch0_wr = wr_lane0 & sel_ch0;
    wire ch1_wr = wr_lane0 & sel_ch1;
    // Separate-lane mode on channel 0 drags channel 1 to multiplexed
    wire next_ch0_mux = ch0_wr ? wr_ctrl.mux : ctrl.mux;
    wire force_ch1_mux = ~next_ch0_mux;

    assign s_axi_awready = ~aw_held;
    assign s_axi_wready = ~w_held;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= '0;
            w_data <= '0;
            w_strb <= '0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `VCC_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= {s_axi_awaddr[`VCC_ADDR_W-1:2], 2'b00};
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_hit ? `VCC_RESP_OKAY : `VCC_RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Control registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl <= unpack_ctrl(`VCC_CTRL_RST);
            ch1_irq_select <= 2'h0;
            ch1_layout <= 1'b0;
            channel1_luma_chroma_mux <= 1'b0;
            channel1_capture_format <= 2'h0;
            channel1_enable <= 1'b0;
            irq_mask <= '0;
        end else begin
            if (ch0_wr) begin
                ctrl <= wr_ctrl;
            end
            if (ch1_wr) begin
                ch1_irq_select <= wr_ctrl.irq_select;
                ch1_layout <= wr_ctrl.layout;
                channel1_capture_format <= wr_ctrl.format;
                channel1_enable <= wr_ctrl.enable;
            end
            if (force_ch1_mux) begin
                channel1_luma_chroma_mux <= 1'b1;
            end else if (ch1_wr) begin
                channel1_luma_chroma_mux <= wr_ctrl.mux;
            end
            if (wr_lane0 && sel_mask) begin
                irq_mask <= wbyte[`VCC_IRQ_W-1:0];
            end
        end
    end

    // Start condition: joint modes wait for both enables
    wire joint_mode = is_raw(ctrl.format) | ~ctrl.mux;
    wire start_ok = ctrl.enable &
                    (~joint_mode | channel1_enable);

    // Setup is latched into the active copy on every vsync fall while armed or running and start_ok still holds
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= VCC_IDLE;
            act <= unpack_ctrl(`VCC_CTRL_RST);
        end else begin
            unique case (state)
                VCC_IDLE: begin
                    if (start_ok) begin
                        state <= VCC_ARM;
                    end
                end
                VCC_ARM: begin
                    if (!start_ok) begin
                        state <= VCC_IDLE;
                    end else if (vs_fall) begin
                        act <= ctrl;
                        state <= VCC_RUN;
                    end
                end
                VCC_RUN: begin
                    if (!start_ok) begin
                        state <= VCC_IDLE;
                    end else if (vs_fall) begin
                        act <= ctrl;
                    end
                end
                default: begin
                    state <= VCC_IDLE;
                end
            endcase
        end
    end

    wire running = state == VCC_RUN;

    // Frame interrupt source selection
    wire sel_top = act.irq_select == `VCC_SEL_TOP;
    wire sel_bot = act.irq_select == `VCC_SEL_BOT;
    wire sel_both = act.irq_select == `VCC_SEL_BOTH;
    wire field_match = sel_both | (sel_top & ~vid_s.field_id) |
                       (sel_bot & vid_s.field_id);
    wire frame_pulse = running & vs_rise & field_match;
    wire start_pulse = (state == VCC_ARM) & vs_fall & start_ok;
    wire act_raw = is_raw(act.format);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            field_identity_flag <= 1'b0;
        end else if (running && act_raw) begin
            field_identity_flag <= vid_s.field_id;
        end else if (frame_pulse) begin
            field_identity_flag <= vid_s.field_id;
        end
    end

    // Sticky status: write one to clear, a new event wins over the clear
    wire stat_clr = wr_lane0 & sel_stat;
    wire [`VCC_IRQ_W-1:0] irq_events = {start_pulse, frame_pulse};
    wire [`VCC_IRQ_W-1:0] clr_bits = stat_clr ?
                                     wbyte[`VCC_IRQ_W-1:0] : '0;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_status <= '0;
        end else begin
            irq_status <= (irq_status & ~clr_bits) | irq_events;
        end
    end

    assign irq = |(irq_status & irq_mask);

    // Capture path towards memory, one byte per link clock rise
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mem_wr_valid <= 1'b0;
            mem_wr_data <= 8'h00;
            mem_wr_subpicture <= 1'b0;
            mem_wr_separate_lanes <= 1'b0;
        end else begin
            mem_wr_valid <= running & clk_rise;
            if (running && clk_rise) begin
                mem_wr_data <= vid_s.data;
                // Sub-picture only for active video in embedded-sync mode
                mem_wr_subpicture <= act.layout & ~act_raw &
                                     ~blank_s;
                mem_wr_separate_lanes <= ~act.mux;
            end
        end
    end

    assign capture_active = running;

    // Read channel
    wire [7:0] ch0_rd = pack_ctrl(ctrl, field_identity_flag);
    wire [7:0] ch1_rd = pack_ctrl(vcc_ctrl_s'({ch1_irq_select, ch1_layout,
                                  channel1_luma_chroma_mux,
                                  channel1_capture_format, channel1_enable}),
                                  1'b0);
    wire [`VCC_ADDR_W-1:0] raddr = {s_axi_araddr[`VCC_ADDR_W-1:2], 2'b00};
    wire rd_ch0 = raddr == `VCC_OFF_CH0;
    wire rd_ch1 = raddr == `VCC_OFF_CH1;
    wire rd_stat = raddr == `VCC_OFF_IRQ_STAT;
    wire rd_mask = raddr == `VCC_OFF_IRQ_MASK;
    wire rd_hit = rd_ch0 | rd_ch1 | rd_stat | rd_mask;
    wire [7:0] rd_byte = rd_ch0 ? ch0_rd :
                         rd_ch1 ? ch1_rd :
                         rd_stat ? 8'(irq_status) :
                         rd_mask ? 8'(irq_mask) : 8'h00;

    assign s_axi_arready = ~s_axi_rvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `VCC_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {24'h000000, rd_byte};
            s_axi_rresp <= rd_hit ? `VCC_RESP_OKAY : `VCC_RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule : vcc_channel_ctrl

// ==== rtl/vcc_edge.sv ====
// Edge finder on a synchronised level
`timescale 1ns/1ps
module vcc_edge (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic level,
    output logic rise,
    output logic fall
);
    logic prev;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            prev <= 1'b0;
        end else begin
            prev <= level;
        end
    end

    assign rise = level & ~prev;
    assign fall = ~level & prev;
endmodule : vcc_edge

// ==== rtl/vcc_pkg.sv ====
// Types shared by the capture channel control files
package vcc_pkg;
    typedef struct packed {
        logic [1:0] irq_select;
        logic layout;
        logic mux;
        logic [1:0] format;
        logic enable;
    } vcc_ctrl_s;

    typedef struct packed {
        logic vsync;
        logic field_id;
        logic [7:0] data;
    } vcc_video_s;

    typedef enum logic [1:0] {
        VCC_IDLE = 2'b00,
        VCC_ARM = 2'b01,
        VCC_RUN = 2'b10
    } vcc_state_e;
endpackage : vcc_pkg

// ==== rtl/vcc_sync.sv ====
// Two-stage synchroniser for a bundle of pin levels
`timescale 1ns/1ps
module vcc_sync #(
    parameter int WIDTH = 1
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage1;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            stage1 <= '0;
            sync_out <= '0;
        end else begin
            stage1 <= async_in;
            sync_out <= stage1;
        end
    end
endmodule : vcc_sync

// ==== verif/testbench.sv ====
// Self-checking bench for the capture channel control block
`timescale 1ns/1ps
`include "vcc_cfg.svh"
module testbench
    import vcc_pkg::*;
;
    logic aclk = 1'b0;
    logic aresetn, src_en;
    int sub_cnt = 0;
    int sub_base = 0;
    int step_cnt = 0;
    logic [7:0] last_data = 8'h00;
    logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic s_axi_rvalid, s_axi_rready;
    logic vid_clk, vid_vsync, vid_field, vid_blank;
    logic [7:0] vid_data, mem_wr_data;
    logic mem_wr_valid, mem_wr_subpicture, mem_wr_separate_lanes;
    logic capture_active, irq;
    int mismatches = 0;
    int num_checks = 0;

    vcc_channel_ctrl DUT (.*);
    vcc_video_src src (.*);

    always #5 aclk = ~aclk;
    // Counts sub-picture writes and captures one step after the last
    always @(posedge aclk) begin
        if (mem_wr_valid && mem_wr_subpicture) sub_cnt <= sub_cnt + 1;
        if (mem_wr_valid) begin
            last_data <= mem_wr_data;
            if (mem_wr_data == last_data + 8'h01) step_cnt <= step_cnt + 1;
        end
    end

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : print_verdict

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e) begin
            mismatches++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask : chk

    task automatic hang(input int k);
        if (k >= 400) begin
            mismatches++;
            print_verdict();
        end
    endtask : hang

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        int k;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (k = 0; k < 400; k++) begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        hang(k);
        chk(32'(s_axi_bresp), 32'(`VCC_RESP_OKAY));
    endtask : wr

    task automatic rd(input logic [3:0] a, input logic [31:0] e,
                      input logic [31:0] m, input logic [1:0] er);
        int k;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (k = 0; k < 400; k++) begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        hang(k);
        chk(s_axi_rdata & m, e);
        chk(32'(s_axi_rresp), 32'(er));
    endtask : rd

    // Waits for n rising vsync edges, then lets the event settle
    task automatic vrise(input int n);
        int k;
        logic p;
        p = vid_vsync;
        for (k = 0; k < 400 && n > 0; k++) begin
            @(posedge aclk);
            if (vid_vsync && !p) begin
                n--;
                k = 0;
            end
            p = vid_vsync;
        end
        hang(k);
        repeat (10) @(posedge aclk);
    endtask : vrise

    initial begin
        aresetn <= 1'b0;
        src_en <= 1'b0;
        s_axi_awaddr <= 4'h0;
        s_axi_araddr <= 4'h0;
        s_axi_wdata <= 32'h0;
        s_axi_wstrb <= 4'hF;
        s_axi_awvalid <= 1'b0;
        s_axi_wvalid <= 1'b0;
        s_axi_bready <= 1'b0;
        s_axi_arvalid <= 1'b0;
        s_axi_rready <= 1'b0;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(`VCC_OFF_CH0, 32'h0, 32'hFF, `VCC_RESP_OKAY);
        rd(`VCC_OFF_CH1, 32'h8, 32'h8, `VCC_RESP_OKAY);
        rd(4'h2, 32'h0, 32'hFFFFFFFF, `VCC_RESP_OKAY);
        wr(`VCC_OFF_CH0, 32'hFFFFFFFE);
        rd(`VCC_OFF_CH0, 32'hDE, 32'hFFFFFFFF, `VCC_RESP_OKAY);
        wr(`VCC_OFF_CH0, 32'h0);
        wr(`VCC_OFF_IRQ_MASK, 32'h3);
        rd(`VCC_OFF_IRQ_MASK, 32'h3, 32'hFFFFFFFF, `VCC_RESP_OKAY);
        src_en <= 1'b1;
        wr(`VCC_OFF_CH0, 32'h1);
        vrise(2);
        chk(32'(capture_active), 32'h0);
        wr(`VCC_OFF_CH1, 32'h1);
        vrise(2);
        chk(32'(capture_active), 32'h1);
        chk(32'(mem_wr_separate_lanes), 32'h1);
        rd(`VCC_OFF_CH1, 32'h9, 32'hFF, `VCC_RESP_OKAY);
        wr(`VCC_OFF_CH0, 32'h0);
        repeat (5) @(posedge aclk);
        chk(32'(capture_active), 32'h0);
        wr(`VCC_OFF_CH1, 32'h0);
        sub_base = sub_cnt;
        wr(`VCC_OFF_CH0, 32'h19);
        vrise(2);
        chk(32'(capture_active), 32'h1);
        chk(32'(step_cnt > 0), 32'h1);
        chk(32'(mem_wr_separate_lanes), 32'h0);
        chk(32'(sub_cnt > sub_base), 32'h1);
        for (int i = 0; i < 4; i++) begin
            wr(`VCC_OFF_CH0, {24'h0, i[1:0], 6'h19});
            vrise(1);
            wr(`VCC_OFF_IRQ_STAT, 32'h3);
            vrise(2);
            rd(`VCC_OFF_IRQ_STAT, 32'(i < 3), 32'h1, `VCC_RESP_OKAY);
            chk(32'(irq), 32'(i < 3));
            if (i < 2) rd(`VCC_OFF_CH0, 32'(i) << 5, 32'h20, 2'h0);
            wr(`VCC_OFF_IRQ_STAT, 32'h3);
            repeat (2) @(posedge aclk);
            chk(32'(irq), 32'h0);
        end
        wr(`VCC_OFF_CH0, 32'h0);
        wr(`VCC_OFF_CH1, 32'h4);
        wr(`VCC_OFF_CH0, 32'h1D);
        vrise(2);
        chk(32'(capture_active), 32'h0);
        wr(`VCC_OFF_CH1, 32'h5);
        vrise(2);
        chk(32'(capture_active), 32'h1);
        sub_base = sub_cnt;
        vrise(1);
        chk(32'(sub_cnt - sub_base), 32'h0);
        rd(`VCC_OFF_CH0, 32'(vid_field) << 5, 32'h20, 2'h0);
        vrise(1);
        rd(`VCC_OFF_CH0, 32'(vid_field) << 5, 32'h20, 2'h0);
        src_en <= 1'b0;
        print_verdict();
    end
endmodule : testbench

// ==== verif/vcc_channel_ctrl_assertions.sv ====
// Port checker for the capture channel control block
`timescale 1ns/1ps
module vcc_checker
    import vcc_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic vid_vsync,
    input wire logic vid_blank,
    input wire logic mem_wr_valid,
    input wire logic mem_wr_subpicture,
    input wire logic capture_active,
    input wire logic irq
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_wr_resp_once: assert property (
        s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response repeated");
    a_rd_resp_once: assert property (
        s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read response repeated");
    a_rd_upper_zero: assert property (
        s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
        else $error("upper read bits not zero");
    a_gate_writes: assert property (
        !capture_active [*2] |-> !mem_wr_valid)
        else $error("memory write while idle");
    a_gate_irq: assert property (
        !capture_active [*4] |-> !$rose(irq))
        else $error("interrupt while idle");
    a_start_vsync: assert property (
        $rose(capture_active) |-> !vid_vsync && !$past(vid_vsync, 3) &&
        $past(vid_vsync, 4))
        else $error("start not after vsync fall");
    a_blank_raster: assert property (
        vid_blank [*8] |-> !mem_wr_subpicture)
        else $error("blanking data in sub-picture");
    a_wr_pulse_gap: assert property (
        mem_wr_valid |=> !mem_wr_valid [*4])
        else $error("write pulses too close");
    c_start: cover property ($rose(capture_active));
    c_irq: cover property ($rose(irq));
    c_sub: cover property (mem_wr_valid && mem_wr_subpicture);
endmodule : vcc_checker

bind vcc_channel_ctrl vcc_checker u_chk (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .s_axi_rdata(s_axi_rdata),
    .vid_vsync(vid_vsync),
    .vid_blank(vid_blank),
    .mem_wr_valid(mem_wr_valid),
    .mem_wr_subpicture(mem_wr_subpicture),
    .capture_active(capture_active),
    .irq(irq)
);

// ==== verif/vcc_video_src.sv ====
// Behavioural video source driving frames on the link pins
`timescale 1ns/1ps
module vcc_video_src (
    input wire logic src_en,
    output logic vid_clk,
    output logic vid_vsync,
    output logic vid_field,
    output logic [7:0] vid_data,
    output logic vid_blank
);
    initial begin
        vid_clk = 1'b0;
        vid_vsync = 1'b1;
        vid_field = 1'b1;
        vid_data = 8'h5A;
        vid_blank = 1'b1;
        forever begin
            if (!src_en) begin
                // Clock stands while the source is disabled, data keeps changing
                #40 vid_data = ~vid_data;
            end else begin
                for (int i = 0; i < 16; i++) begin
                    #40 vid_clk = 1'b0;
                    vid_data = vid_data + 8'h01;
                    if (i == 0) begin
                        vid_vsync = 1'b0;
                        vid_blank = 1'b0;
                        vid_field = ~vid_field;
                    end
                    if (i == 12) begin
                        vid_vsync = 1'b1;
                        vid_blank = 1'b1;
                    end
                    #40 vid_clk = 1'b1;
                end
            end
        end
    end
endmodule : vcc_video_src
